// ===== hw/usf_status_bank.sv
/*
  Read-only bank of six 16-bit status words for a power system, read over classic Wishbone.
  Assumes every condition input comes from pins outside the clock domain, the bypass
  contactor command comes from logic on clk_sys_i, and the bus master keeps classic
  single-cycle Wishbone handshakes.
*/
// Design decisions made here: the address map and register access over Wishbone.
// Function
// RULE_01: Words are 16 bits, bit 15 most significant.
// RULE_02: Cabinet word 1 bits 15-12: board links good.
// RULE_03: Cabinet word 1 bits 11-9: transformer fuses intact.
// RULE_04: Cabinet word 1 bits 7,6: 24 V supplies.
// RULE_05: Cabinet word 1 bits 2-0: fans; spares.
// RULE_06: Cabinet word 2 bit 15: static switch fuse.
// RULE_07: Cabinet word 2 bits 6-1: remote contacts.
// RULE_08: Cabinet word 3 bits 15-13: rotation, frequency lock.
// RULE_09: Cabinet word 3 bit 8: bypass contactor mismatch.
// RULE_10: Cabinet word 3 bit 7: satellite link error.
// RULE_11: Cabinet word 3 bit 6: bypass breaker trip.
// RULE_12: Cabinet word 3 bits 1,0: zigzag relay trips.
// RULE_13: Module word A bits 15-13: contactors closed.
// RULE_14: Module word A bits 12-7: board links good.
// RULE_15: Module word A bit 6: unload setpoint timeout.
// RULE_16: Module word A bit 5: low speed discharge end.
// RULE_17: Module word A bits 4-0: controller, switch states.
// RULE_18: Module word B bits 10,9: transformer fuses.
// RULE_19: Module word B bits 8-6 supplies, 5-0 fans.
// RULE_20: Module word C bits 14,13: input rotation.
// RULE_21: Module word C bits 12,11: switch ramp, timeout.
// RULE_22: Module word C bits 10-0: drive fault flags.
// RULE_23: Spares read zero; software writes ignored.
// RULE_24: Sources synchronised; each read is coherent snapshot.
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"

module usf_status_bank (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire usf_pkg::usf_src_type status_src_i,
  input wire logic bypass_contactor_command_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import usf_pkg::*;

  usf_src_type src_meta;
  usf_src_type src_sync;
  logic [`USF_WORD_W-1:0] status_word [`USF_WORD_COUNT];
  logic [`USF_WORD_W-1:0] next_word [`USF_WORD_COUNT];
  usf_sel_type bus_sel;
  logic [`USF_WORD_W-1:0] sel_word;
  logic bus_req;
  logic [`USF_SRC_LATENCY-1:0] settle;
  logic settled;

  // Maps a byte address onto a word index; anything off the map is a miss.
  function automatic usf_sel_type usf_decode(input logic [7:0] adr);
    usf_sel_type sel;
    sel.hit = 1'b1;
    case (adr)
      `USF_OFS_CAB_HEALTH: sel.idx = `USF_IDX_CAB_HEALTH;
      `USF_OFS_CAB_CONTACTS: sel.idx = `USF_IDX_CAB_CONTACTS;
      `USF_OFS_CAB_FAULT: sel.idx = `USF_IDX_CAB_FAULT;
      `USF_OFS_MOD_CONTACTOR: sel.idx = `USF_IDX_MOD_CONTACTOR;
      `USF_OFS_MOD_SUPPLY: sel.idx = `USF_IDX_MOD_SUPPLY;
      `USF_OFS_MOD_DRIVE: sel.idx = `USF_IDX_MOD_DRIVE;
      default: begin
        sel.hit = 1'b0;
        sel.idx = `USF_IDX_CAB_HEALTH;
      end
    endcase
    return sel;
  endfunction

  // The first stage is read only by the second stage.
  // RULE_24: two-flop source synchroniser
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= status_src_i;
      src_sync <= src_meta;
    end
  end

  always_comb begin
    for (int i = 0; i < `USF_WORD_COUNT; i++) begin
      // RULE_23: spares default zero
      next_word[i] = `USF_WORD_RESET;
    end
    // RULE_02: cabinet board links
    next_word[`USF_IDX_CAB_HEALTH][`USF_C1_LINK_LO +: `USF_C1_LINK_W] = src_sync.cab_health.board_link_ok;
    // RULE_03: cabinet transformer fuses
    next_word[`USF_IDX_CAB_HEALTH][`USF_C1_FUSE_LO +: `USF_C1_FUSE_W] =
      src_sync.cab_health.cabinet_transformer_fuse_ok;
    // RULE_04: cabinet supplies
    next_word[`USF_IDX_CAB_HEALTH][`USF_C1_SUPPLY_LO +: `USF_C1_SUPPLY_W] = src_sync.cab_health.cabinet_supply_ok;
    // RULE_05: cabinet fans
    next_word[`USF_IDX_CAB_HEALTH][`USF_C1_FAN_LO +: `USF_C1_FAN_W] = src_sync.cab_health.cabinet_fan_ok;
    // RULE_06: static switch fuse
    next_word[`USF_IDX_CAB_CONTACTS][`USF_C2_SS_FUSE] = src_sync.cab_contacts.static_switch_fuse_ok;
    // RULE_07: remote input contacts
    next_word[`USF_IDX_CAB_CONTACTS][`USF_C2_CONTACT_LO +: `USF_C2_CONTACT_W] =
      src_sync.cab_contacts.remote_contact;
    // RULE_08: bypass rotation, lock
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_ROT_CW] = src_sync.cab_fault.bypass_rotation_clockwise;
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_ROT_CCW] = src_sync.cab_fault.bypass_rotation_counterclockwise;
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_FREQ_LOCK] = src_sync.cab_fault.frequency_locked;
    // RULE_09: feedback against command
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_MISMATCH] =
      src_sync.cab_fault.bypass_contactor_feedback ^ bypass_contactor_command_i;
    // A lost lock on any cabinet board also counts as a satellite link error.
    // RULE_10: satellite link error
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_COMM_ERR] =
      src_sync.cab_fault.satellite_link_error | ~(&src_sync.cab_health.board_link_ok);
    // RULE_11: bypass breaker trip
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_CB_TRIP] = src_sync.cab_fault.bypass_breaker_overcurrent_trip;
    // RULE_12: zigzag relay trips
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_ZZ_OVERLOAD] = src_sync.cab_fault.zigzag_overload_relay_trip;
    next_word[`USF_IDX_CAB_FAULT][`USF_C3_ZZ_BREAKER] = src_sync.cab_fault.zigzag_breaker_trip;
    // The module contactor word is packed in bit order, so it maps whole.
    // RULE_13: module contactor word
    // RULE_14: module board links
    // RULE_15: unload setpoint timeout
    // RULE_16: low speed end
    // RULE_17: controller, switch states
    next_word[`USF_IDX_MOD_CONTACTOR] = src_sync.mod_contactor;
    next_word[`USF_IDX_MOD_SUPPLY][`USF_MB_DISCHARGE] = src_sync.mod_supply.discharge_active;
    // RULE_18: module transformer fuses
    next_word[`USF_IDX_MOD_SUPPLY][`USF_MB_FUSE_LO +: `USF_MB_FUSE_W] =
      src_sync.mod_supply.module_transformer_fuse_ok;
    // RULE_19: module supplies, fans
    next_word[`USF_IDX_MOD_SUPPLY][`USF_MB_SUPPLY_LO +: `USF_MB_SUPPLY_W] = src_sync.mod_supply.module_supply_ok;
    next_word[`USF_IDX_MOD_SUPPLY][`USF_MB_FAN_LO +: `USF_MB_FAN_W] = src_sync.mod_supply.module_fan_ok;
    // RULE_20: input phase rotation
    // RULE_21: input switch ramp
    // RULE_22: module drive faults
    next_word[`USF_IDX_MOD_DRIVE][`USF_MC_FLAGS_W-1:0] = src_sync.mod_drive;
  end

  // All words are refreshed on the same edge so a read never mixes two samples.
  // RULE_24: whole-word snapshot
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < `USF_WORD_COUNT; i++) begin
        status_word[i] <= `USF_WORD_RESET;
      end
    end else begin
      for (int i = 0; i < `USF_WORD_COUNT; i++) begin
        status_word[i] <= next_word[i];
      end
    end
  end

  assign bus_sel = usf_decode(wb_adr_i);
  assign sel_word = status_word[bus_sel.idx];
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Writes and unmapped reads are acknowledged with zero data; byte enables are not needed.
  // RULE_23: writes ignored
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= `USF_BUS_IDLE;
    end else if (bus_req) begin
      if (bus_sel.hit && !wb_we_i) begin
        // RULE_01: sixteen bits, low lanes
        wb_dat_o <= {`USF_BUS_PAD, sel_word};
      end else begin
        wb_dat_o <= `USF_BUS_IDLE;
      end
    end
  end

  // Checks on the status words below only start once every pipeline stage holds post-reset samples.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle <= '0;
    end else begin
      settle <= {settle[`USF_SRC_LATENCY-2:0], 1'b1};
    end
  end
  assign settled = settle[`USF_SRC_LATENCY-1];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_req_open;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_read_hit;
    s_req_open ##0 (!wb_we_i && bus_sel.hit);
  endsequence

  sequence s_write_req;
    s_req_open ##0 wb_we_i;
  endsequence

  sequence s_read_miss;
    s_req_open ##0 (!wb_we_i && !bus_sel.hit);
  endsequence

  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:16] == `USF_BUS_PAD;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Upper half of read data not zero."); // RULE_01

  property p_cab_links;
    settled |-> status_word[`USF_IDX_CAB_HEALTH][15:12] ==
      $past(status_src_i.cab_health.board_link_ok, 3);
  endproperty
  a_cab_links: assert property (p_cab_links) else $error("Cabinet link bits wrong."); // RULE_02

  property p_cab_fuses;
    settled |-> status_word[`USF_IDX_CAB_HEALTH][11:9] ==
      $past(status_src_i.cab_health.cabinet_transformer_fuse_ok, 3);
  endproperty
  a_cab_fuses: assert property (p_cab_fuses) else $error("Cabinet fuse bits wrong."); // RULE_03

  property p_cab_supplies;
    settled |-> status_word[`USF_IDX_CAB_HEALTH][7:6] ==
      $past(status_src_i.cab_health.cabinet_supply_ok, 3);
  endproperty
  a_cab_supplies: assert property (p_cab_supplies) else $error("Cabinet supply bits wrong."); // RULE_04

  property p_cab_fans;
    settled |-> status_word[`USF_IDX_CAB_HEALTH][2:0] == $past(status_src_i.cab_health.cabinet_fan_ok, 3)
      && status_word[`USF_IDX_CAB_HEALTH][8] == 1'b0 && status_word[`USF_IDX_CAB_HEALTH][5:3] == 3'h0;
  endproperty
  a_cab_fans: assert property (p_cab_fans) else $error("Cabinet fan or spare bits wrong."); // RULE_05

  property p_cab_ss_fuse;
    settled |-> status_word[`USF_IDX_CAB_CONTACTS][15] == $past(status_src_i.cab_contacts.static_switch_fuse_ok, 3)
      && status_word[`USF_IDX_CAB_CONTACTS][14:7] == 8'h00;
  endproperty
  a_cab_ss_fuse: assert property (p_cab_ss_fuse) else $error("Static switch fuse bit wrong."); // RULE_06

  property p_cab_contacts;
    settled |-> status_word[`USF_IDX_CAB_CONTACTS][6:1] == $past(status_src_i.cab_contacts.remote_contact, 3)
      && status_word[`USF_IDX_CAB_CONTACTS][0] == 1'b0;
  endproperty
  a_cab_contacts: assert property (p_cab_contacts) else $error("Remote contact bits wrong."); // RULE_07

  property p_bypass_rotation;
    settled |-> status_word[`USF_IDX_CAB_FAULT][15:13] == {$past(status_src_i.cab_fault.bypass_rotation_clockwise, 3),
      $past(status_src_i.cab_fault.bypass_rotation_counterclockwise, 3),
      $past(status_src_i.cab_fault.frequency_locked, 3)};
  endproperty
  a_bypass_rotation: assert property (p_bypass_rotation) else $error("Bypass rotation bits wrong."); // RULE_08

  property p_bypass_mismatch;
    settled |-> status_word[`USF_IDX_CAB_FAULT][8] ==
      ($past(status_src_i.cab_fault.bypass_contactor_feedback, 3) ^ $past(bypass_contactor_command_i, 1));
  endproperty
  a_bypass_mismatch: assert property (p_bypass_mismatch) else $error("Bypass mismatch bit wrong."); // RULE_09

  property p_comm_error;
    settled && !status_word[`USF_IDX_CAB_FAULT][7] |-> &status_word[`USF_IDX_CAB_HEALTH][15:12];
  endproperty
  a_comm_error: assert property (p_comm_error) else $error("Lost board lock without link error."); // RULE_10

  // Lost board locks count as link errors as well, so both sources are checked.
  property p_link_error;
    settled |-> status_word[`USF_IDX_CAB_FAULT][7] == ($past(status_src_i.cab_fault.satellite_link_error, 3)
      | ~(&$past(status_src_i.cab_health.board_link_ok, 3)));
  endproperty
  a_link_error: assert property (p_link_error) else $error("Satellite link error bit wrong."); // RULE_10

  property p_cb_trip;
    settled |-> status_word[`USF_IDX_CAB_FAULT][6] ==
      $past(status_src_i.cab_fault.bypass_breaker_overcurrent_trip, 3);
  endproperty
  a_cb_trip: assert property (p_cb_trip) else $error("Breaker trip bit wrong."); // RULE_11

  property p_zigzag;
    settled |-> status_word[`USF_IDX_CAB_FAULT][1:0] == {$past(status_src_i.cab_fault.zigzag_overload_relay_trip, 3),
      $past(status_src_i.cab_fault.zigzag_breaker_trip, 3)} && status_word[`USF_IDX_CAB_FAULT][5:2] == 4'h0;
  endproperty
  a_zigzag: assert property (p_zigzag) else $error("Zigzag trip bits wrong."); // RULE_12

  property p_mod_contactors;
    settled |-> status_word[`USF_IDX_MOD_CONTACTOR][15:13] == $past(status_src_i.mod_contactor[15:13], 3);
  endproperty
  a_mod_contactors: assert property (p_mod_contactors) else $error("Module contactor bits wrong."); // RULE_13

  property p_mod_links;
    settled |-> status_word[`USF_IDX_MOD_CONTACTOR][12:7] == $past(status_src_i.mod_contactor[12:7], 3);
  endproperty
  a_mod_links: assert property (p_mod_links) else $error("Module link bits wrong."); // RULE_14

  property p_unload_timeout;
    settled |-> status_word[`USF_IDX_MOD_CONTACTOR][6] ==
      $past(status_src_i.mod_contactor.unload_setpoint_timeout, 3);
  endproperty
  a_unload_timeout: assert property (p_unload_timeout) else $error("Unload timeout bit wrong."); // RULE_15

  property p_low_speed;
    settled |-> status_word[`USF_IDX_MOD_CONTACTOR][5] == $past(status_src_i.mod_contactor.low_speed_discharge_end, 3);
  endproperty
  a_low_speed: assert property (p_low_speed) else $error("Low speed bit wrong."); // RULE_16

  property p_mod_controls;
    settled |-> status_word[`USF_IDX_MOD_CONTACTOR][4:0] == $past(status_src_i.mod_contactor[4:0], 3);
  endproperty
  a_mod_controls: assert property (p_mod_controls) else $error("Module control bits wrong."); // RULE_17

  property p_mod_fuses;
    settled |-> status_word[`USF_IDX_MOD_SUPPLY][10:9] ==
      $past(status_src_i.mod_supply.module_transformer_fuse_ok, 3);
  endproperty
  a_mod_fuses: assert property (p_mod_fuses) else $error("Module fuse bits wrong."); // RULE_18

  property p_mod_supply_fans;
    settled |-> status_word[`USF_IDX_MOD_SUPPLY][8:0] == {$past(status_src_i.mod_supply.module_supply_ok, 3),
      $past(status_src_i.mod_supply.module_fan_ok, 3)};
  endproperty
  a_mod_supply_fans: assert property (p_mod_supply_fans) else $error("Module supply or fan bits wrong."); // RULE_19

  property p_input_rotation;
    settled |-> status_word[`USF_IDX_MOD_DRIVE][14:13] == $past(status_src_i.mod_drive[14:13], 3);
  endproperty
  a_input_rotation: assert property (p_input_rotation) else $error("Input rotation bits wrong."); // RULE_20

  property p_input_switch;
    settled |-> status_word[`USF_IDX_MOD_DRIVE][12:11] == $past(status_src_i.mod_drive[12:11], 3);
  endproperty
  a_input_switch: assert property (p_input_switch) else $error("Input switch bits wrong."); // RULE_21

  property p_drive_faults;
    settled |-> status_word[`USF_IDX_MOD_DRIVE][10:0] == $past(status_src_i.mod_drive[10:0], 3)
      && status_word[`USF_IDX_MOD_DRIVE][15] == 1'b0;
  endproperty
  a_drive_faults: assert property (p_drive_faults) else $error("Drive fault bits wrong."); // RULE_22

  property p_write_ignored;
    s_write_req |=> wb_ack_o && wb_dat_o == `USF_BUS_IDLE ##1 !wb_ack_o;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("Write not answered with zero."); // RULE_23

  property p_read_miss;
    s_read_miss |=> wb_ack_o && wb_dat_o == `USF_BUS_IDLE;
  endproperty
  a_read_miss: assert property (p_read_miss) else $error("Unmapped read not answered with zero."); // RULE_23

  property p_spare_zero;
    settled |-> status_word[`USF_IDX_CAB_FAULT][12:9] == 4'h0 && status_word[`USF_IDX_MOD_SUPPLY][15:14] == 2'h0
      && status_word[`USF_IDX_MOD_SUPPLY][12:11] == 2'h0;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("Spare status bits not zero."); // RULE_23

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("Acknowledge held longer than one cycle."); // RULE_24

  property p_read_coherent;
    s_read_hit |=> wb_ack_o && wb_dat_o[15:0] == $past(sel_word, 1);
  endproperty
  a_read_coherent: assert property (p_read_coherent) else $error("Read data not the sampled word."); // RULE_24

endmodule

`default_nettype wire

// ===== inc/usf_params.svh
/*
  Offsets, field positions, reset values and latency of the status flag bank.
  Assumes it is included by its bare name from the package and the design file.
*/
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH

`define USF_WORD_W 16
`define USF_WORD_COUNT 6
`define USF_WORD_RESET 16'h0000
`define USF_BUS_PAD 16'h0000
`define USF_BUS_IDLE 32'h0000_0000
`define USF_SRC_LATENCY 3

`define USF_OFS_CAB_HEALTH 8'h00
`define USF_OFS_CAB_CONTACTS 8'h04
`define USF_OFS_CAB_FAULT 8'h08
`define USF_OFS_MOD_CONTACTOR 8'h0C
`define USF_OFS_MOD_SUPPLY 8'h10
`define USF_OFS_MOD_DRIVE 8'h14

`define USF_IDX_CAB_HEALTH 3'h0
`define USF_IDX_CAB_CONTACTS 3'h1
`define USF_IDX_CAB_FAULT 3'h2
`define USF_IDX_MOD_CONTACTOR 3'h3
`define USF_IDX_MOD_SUPPLY 3'h4
`define USF_IDX_MOD_DRIVE 3'h5

`define USF_C1_LINK_LO 12
`define USF_C1_LINK_W 4
`define USF_C1_FUSE_LO 9
`define USF_C1_FUSE_W 3
`define USF_C1_SUPPLY_LO 6
`define USF_C1_SUPPLY_W 2
`define USF_C1_FAN_LO 0
`define USF_C1_FAN_W 3

`define USF_C2_SS_FUSE 15
`define USF_C2_CONTACT_LO 1
`define USF_C2_CONTACT_W 6

`define USF_C3_ROT_CW 15
`define USF_C3_ROT_CCW 14
`define USF_C3_FREQ_LOCK 13
`define USF_C3_MISMATCH 8
`define USF_C3_COMM_ERR 7
`define USF_C3_CB_TRIP 6
`define USF_C3_ZZ_OVERLOAD 1
`define USF_C3_ZZ_BREAKER 0

`define USF_MB_DISCHARGE 13
`define USF_MB_FUSE_LO 9
`define USF_MB_FUSE_W 2
`define USF_MB_SUPPLY_LO 6
`define USF_MB_SUPPLY_W 3
`define USF_MB_FAN_LO 0
`define USF_MB_FAN_W 6

`define USF_MC_STAGE_W 3
`define USF_MC_FLAGS_W 15

`endif

// ===== inc/usf_pkg.sv
/*
  Types of the status flag bank: grouped source conditions and the address decode result.
  Assumes usf_params.svh is on the include path.
*/
`include "usf_params.svh"

package usf_pkg;

  typedef struct packed {
    logic [`USF_C1_LINK_W-1:0] board_link_ok;
    logic [`USF_C1_FUSE_W-1:0] cabinet_transformer_fuse_ok;
    logic [`USF_C1_SUPPLY_W-1:0] cabinet_supply_ok;
    logic [`USF_C1_FAN_W-1:0] cabinet_fan_ok;
  } usf_cab_health_type;

  typedef struct packed {
    logic static_switch_fuse_ok;
    logic [`USF_C2_CONTACT_W-1:0] remote_contact;
  } usf_cab_contacts_type;

  typedef struct packed {
    logic bypass_rotation_clockwise;
    logic bypass_rotation_counterclockwise;
    logic frequency_locked;
    logic bypass_contactor_feedback;
    logic satellite_link_error;
    logic bypass_breaker_overcurrent_trip;
    logic zigzag_overload_relay_trip;
    logic zigzag_breaker_trip;
  } usf_cab_fault_type;

  typedef struct packed {
    logic bypass_contactor_closed;
    logic output_contactor_closed;
    logic input_contactor_closed;
    logic user_board_link_ok;
    logic io_board_link_ok;
    logic fan_board_link_ok;
    logic module_dc_board_link_ok;
    logic module_ac_board_link_ok;
    logic generator_start_board_link_ok;
    logic unload_setpoint_timeout;
    logic low_speed_discharge_end;
    logic flywheel_master_on;
    logic external_sync_command;
    logic static_switch_contactor_state;
    logic static_switch_fuse_state;
    logic module_master_on;
  } usf_mod_contactor_type;

  typedef struct packed {
    logic discharge_active;
    logic [`USF_MB_FUSE_W-1:0] module_transformer_fuse_ok;
    logic [`USF_MB_SUPPLY_W-1:0] module_supply_ok;
    logic [`USF_MB_FAN_W-1:0] module_fan_ok;
  } usf_mod_supply_type;

  typedef struct packed {
    logic input_rotation_counterclockwise;
    logic input_rotation_clockwise;
    logic input_switch_ramp_finished;
    logic input_switch_timeout;
    logic flywheel_overspeed;
    logic rotor_position_sensor_fault;
    logic [`USF_MC_STAGE_W-1:0] flywheel_power_stage_fault;
    logic [`USF_MC_STAGE_W-1:0] utility_inverter_phase_fault;
    logic flywheel_interface_link_error;
    logic dc_bus_undervoltage;
    logic dc_bus_overvoltage;
  } usf_mod_drive_type;

  typedef struct packed {
    usf_cab_health_type cab_health;
    usf_cab_contacts_type cab_contacts;
    usf_cab_fault_type cab_fault;
    usf_mod_contactor_type mod_contactor;
    usf_mod_supply_type mod_supply;
    usf_mod_drive_type mod_drive;
  } usf_src_type;

  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } usf_sel_type;

endpackage

// ===== verification/test_ups_status_flag_bank.sv
/*
  Self-checking bench for the status flag bank: corner and random pin patterns, bus reads,
  ignored writes, unmapped addresses and a second reset in mid-run.
  Assumes usf_pkg is compiled first and usf_params.svh is on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"

module test_ups_status_flag_bank;
  import usf_pkg::*;

  logic clk_sys_i;
  logic reset_n_i;
  usf_src_type src;
  usf_src_type next_src;
  logic cmd;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  int fail_count;
  int checked;
  logic [7:0] ofs [6];
  logic [7:0] bad_ofs [4];
  logic [95:0] rnd;
  logic [31:0] got;
  logic [31:0] old_word;

  usf_status_bank i_dut (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .status_src_i(src),
    .bypass_contactor_command_i(cmd),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Expected word from the pins, with the command held steady for several cycles.
  function automatic logic [31:0] expect_word(input logic [2:0] idx, input usf_src_type s, input logic c);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      `USF_IDX_CAB_HEALTH: w = {s.cab_health.board_link_ok, s.cab_health.cabinet_transformer_fuse_ok, 1'b0,
        s.cab_health.cabinet_supply_ok, 3'h0, s.cab_health.cabinet_fan_ok};
      `USF_IDX_CAB_CONTACTS: w = {s.cab_contacts.static_switch_fuse_ok, 8'h00, s.cab_contacts.remote_contact, 1'b0};
      `USF_IDX_CAB_FAULT: w = {s.cab_fault.bypass_rotation_clockwise, s.cab_fault.bypass_rotation_counterclockwise,
        s.cab_fault.frequency_locked, 4'h0, s.cab_fault.bypass_contactor_feedback ^ c,
        s.cab_fault.satellite_link_error | ~(&s.cab_health.board_link_ok), s.cab_fault.bypass_breaker_overcurrent_trip,
        4'h0, s.cab_fault.zigzag_overload_relay_trip, s.cab_fault.zigzag_breaker_trip};
      `USF_IDX_MOD_CONTACTOR: w = s.mod_contactor;
      `USF_IDX_MOD_SUPPLY: w = {2'h0, s.mod_supply.discharge_active, 2'h0, s.mod_supply.module_transformer_fuse_ok,
        s.mod_supply.module_supply_ok, s.mod_supply.module_fan_ok};
      `USF_IDX_MOD_DRIVE: w = {1'b0, s.mod_drive};
      default: w = 16'h0000;
    endcase
    return {16'h0000, w};
  endfunction

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check_word("bus answer", 32'h0000_0001, {31'h0, ack});
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic check_one(input int i);
    bus_cycle(1'b0, ofs[i], 32'h0, got);
    check_word($sformatf("word %0d", i), expect_word(i[2:0], src, cmd), got);
  endtask

  task automatic check_bank;
    check_one(0);
    check_one(1);
    check_one(2);
    check_one(3);
    check_one(4);
    check_one(5);
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys_i);
    fail_count++;
    complete_run();
  end

  initial begin
    reset_n_i = 1'b0;
    src = '0;
    cmd = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    fail_count = 0;
    checked = 0;
    ofs = '{`USF_OFS_CAB_HEALTH, `USF_OFS_CAB_CONTACTS, `USF_OFS_CAB_FAULT,
      `USF_OFS_MOD_CONTACTOR, `USF_OFS_MOD_SUPPLY, `USF_OFS_MOD_DRIVE};
    bad_ofs = '{8'h18, 8'h02, 8'hFC, 8'h13};
    void'($urandom(32'h4DB83272));
    repeat (12) @(posedge clk_sys_i);
    check_word("reset answer", 32'h0, {rdat[31:1], rdat[0] | ack});
    reset_n_i <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      rnd = {$urandom, $urandom, $urandom};
      next_src = rnd[69:0];
      if (k == 0) next_src = '0;
      if (k == 1) next_src = '1;
      if (k >= 2 && k < 6) begin
        next_src = '1;
        next_src.cab_health.board_link_ok[k - 2] = 1'b0;
        next_src.cab_fault.satellite_link_error = 1'b0;
      end
      @(posedge clk_sys_i);
      src <= next_src;
      cmd <= (k < 6) ? k[0] : rnd[95];
      repeat (4) @(posedge clk_sys_i);
      check_bank(); // Every word follows its pins.
    end
    old_word = expect_word(`USF_IDX_CAB_HEALTH, src, cmd);
    @(posedge clk_sys_i);
    src <= ~src;
    bus_cycle(1'b0, `USF_OFS_CAB_HEALTH, 32'h0, got);
    check_word("snapshot before sync", old_word, got);
    repeat (4) @(posedge clk_sys_i);
    check_bank(); // Snapshot after the pins settle.
    for (int i = 0; i < 6; i++) begin
      bus_cycle(1'b1, ofs[i], $urandom, got);
      check_word("write answer", 32'h0, got);
    end
    check_bank(); // Words unchanged by writes.
    for (int i = 0; i < 4; i++) begin
      bus_cycle(1'b0, bad_ofs[i], 32'h0, got);
      check_word("unmapped read", 32'h0, got);
      bus_cycle(1'b1, bad_ofs[i], 32'hFFFF_FFFF, got);
      check_word("unmapped write", 32'h0, got);
    end
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check_word("second reset answer", 32'h0, {rdat[31:1], rdat[0] | ack});
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check_bank(); // Bank recovers after reset.
    complete_run();
  end
endmodule
`default_nettype wire
